// file: logic/dual_counter_timer.sv
`timescale 1ns/1ps
module dual_counter_timer (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Mode and clock selection
  input  wire logic [1:0] first_mode_i,
  input  wire logic [1:0] second_mode_i,
  input  wire logic       first_count_select_i,
  input  wire logic       second_count_select_i,
  input  wire logic       first_sysclk_select_i,
  input  wire logic       second_sysclk_select_i,
  input  wire logic [1:0] prescale_field_i,
  // Run, gate and polarity
  input  wire logic       first_run_bit_i,
  input  wire logic       second_run_bit_i,
  input  wire logic       first_gate_bit_i,
  input  wire logic       second_gate_bit_i,
  input  wire logic       first_gate_polarity_i,
  input  wire logic       second_gate_polarity_i,
  // Interrupt enables and flag clears
  input  wire logic       first_irq_enable_i,
  input  wire logic       second_irq_enable_i,
  input  wire logic       first_flag_clear_i,
  input  wire logic       second_flag_clear_i,
  input  wire logic       first_vector_ack_i,
  input  wire logic       second_vector_ack_i,
  // Pins
  input  wire logic       first_count_pin_i,
  input  wire logic       second_count_pin_i,
  input  wire logic       first_gate_input_i,
  input  wire logic       second_gate_input_i,
  input  wire logic       ext_clk_tick_i,
  // Byte writes
  input  wire logic       first_low_wr_i,
  input  wire logic       first_high_wr_i,
  input  wire logic       second_low_wr_i,
  input  wire logic       second_high_wr_i,
  input  wire logic [7:0] wr_data_i,
  // Counts
  output logic      [7:0] first_timer_low_byte_o,
  output logic      [7:0] first_timer_high_byte_o,
  output logic      [7:0] second_timer_low_byte_o,
  output logic      [7:0] second_timer_high_byte_o,
  // Flags and interrupt requests
  output logic            first_overflow_flag_o,
  output logic            second_overflow_flag_o,
  output logic            first_irq_o,
  output logic            second_irq_o
);

  typedef enum logic [1:0] {
    PIN_SAMPLE = 2'h1,
    PIN_HOLD   = 2'h2
  } pin_state_type;

  logic [5:0] div_q;
  logic [5:0] div_max;
  logic       div_tick;
  logic [2:0] ext_div_q;
  logic       ext_tick;
  logic       presc_tick;
  logic [1:0] cnt_meta_q;
  logic [1:0] cnt_sync_q;
  logic [1:0] cnt_prev_q;
  logic [1:0] gate_meta_q;
  logic [1:0] gate_sync_q;
  logic [1:0] pin_fall;
  logic [1:0] gate_active;
  logic [1:0] ovf;
  logic [1:0] flag_clear;
  logic [1:0] flags_q;
  logic [7:0] low_b [2];
  logic [7:0] high_b [2];
  pin_state_type pin_state_q;

  always_comb begin
    case (prescale_field_i)
      dual_timer_pkg::SCALE_DIV12:
        div_max = 6'(dual_timer_pkg::DIV12_CYCLES - 1);
      dual_timer_pkg::SCALE_DIV4:
        div_max = 6'(dual_timer_pkg::DIV4_CYCLES - 1);
      dual_timer_pkg::SCALE_DIV48:
        div_max = 6'(dual_timer_pkg::DIV48_CYCLES - 1);
      default:
        div_max = 6'(dual_timer_pkg::DIV48_CYCLES - 1);
    endcase
  end

  // Prescaler divider for system clock rates
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= dual_timer_pkg::DIV_RESET;
    end else if (div_q >= div_max) begin
      div_q <= dual_timer_pkg::DIV_RESET;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  assign div_tick = (div_q >= div_max);

  // External clock ticks divided by eight
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_div_q <= 3'h0;
    end else if (ext_clk_tick_i) begin
      ext_div_q <= ext_div_q + 3'h1;
    end
  end

  assign ext_tick = ext_clk_tick_i &&
                    (ext_div_q == 3'(dual_timer_pkg::DIV8_CYCLES - 1));
  assign presc_tick = (prescale_field_i == dual_timer_pkg::SCALE_EXT8) ?
                      ext_tick : div_tick;

  // Two-stage synchronisers for count and gate pins; ext_clk_tick_i is not synchronised
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_meta_q  <= 2'h3;
      cnt_sync_q  <= 2'h3;
      gate_meta_q <= 2'h0;
      gate_sync_q <= 2'h0;
    end else begin
      cnt_meta_q  <= {second_count_pin_i, first_count_pin_i};
      cnt_sync_q  <= cnt_meta_q;
      gate_meta_q <= {second_gate_input_i, first_gate_input_i};
      gate_sync_q <= gate_meta_q;
    end
  end

  // Previous-sample register; edge detect masked one cycle after reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_state_q <= PIN_HOLD;
      cnt_prev_q  <= 2'h3;
    end else begin
      case (pin_state_q)
        PIN_HOLD: begin
          pin_state_q <= PIN_SAMPLE;
          cnt_prev_q  <= cnt_sync_q;
        end
        PIN_SAMPLE: begin
          cnt_prev_q  <= cnt_sync_q;
        end
        default: begin
          pin_state_q <= PIN_HOLD;
        end
      endcase
    end
  end

  assign pin_fall = (pin_state_q == PIN_SAMPLE) ?
                    (cnt_prev_q & ~cnt_sync_q) : 2'h0;
  assign gate_active = ~(gate_sync_q ^
                    {second_gate_polarity_i, first_gate_polarity_i});

  assign flag_clear = {second_flag_clear_i | second_vector_ack_i,
                       first_flag_clear_i | first_vector_ack_i};

  // Two identical channels
  for (genvar g = 0; g < 2; g++) begin : g_chan
    timer_channel u_chan (
      .clk_i           (clk_i),
      .rstn_i          (rstn_i),
      .mode_i          (g == 0 ? first_mode_i : second_mode_i),
      .count_select_i  (g == 0 ? first_count_select_i
                                : second_count_select_i),
      .sysclk_select_i (g == 0 ? first_sysclk_select_i
                                : second_sysclk_select_i),
      .run_i           (g == 0 ? first_run_bit_i : second_run_bit_i),
      .gate_i          (g == 0 ? first_gate_bit_i : second_gate_bit_i),
      .gate_active_i   (gate_active[g]),
      .presc_tick_i    (presc_tick),
      .pin_fall_i      (pin_fall[g]),
      .wr_low_i        (g == 0 ? first_low_wr_i : second_low_wr_i),
      .wr_high_i       (g == 0 ? first_high_wr_i : second_high_wr_i),
      .wr_data_i       (wr_data_i),
      .low_o           (low_b[g]),
      .high_o          (high_b[g]),
      .ovf_o           (ovf[g])
    );

    // Set wins over clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        flags_q[g] <= 1'b0;
      end else if (ovf[g]) begin
        flags_q[g] <= 1'b1;
      end else if (flag_clear[g]) begin
        flags_q[g] <= 1'b0;
      end
    end
  end

  assign first_timer_low_byte_o   = low_b[0];
  assign first_timer_high_byte_o  = high_b[0];
  assign second_timer_low_byte_o  = low_b[1];
  assign second_timer_high_byte_o = high_b[1];
  assign first_overflow_flag_o    = flags_q[0];
  assign second_overflow_flag_o   = flags_q[1];

  // Interrupt requests registered from flags
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_irq_o  <= 1'b0;
      second_irq_o <= 1'b0;
    end else begin
      first_irq_o  <= (flags_q[0] | ovf[0]) & ~(flag_clear[0] & ~ovf[0]) &
                      first_irq_enable_i;
      second_irq_o <= (flags_q[1] | ovf[1]) & ~(flag_clear[1] & ~ovf[1]) &
                      second_irq_enable_i;
    end
  end

endmodule : dual_counter_timer

// file: logic/dual_timer_pkg.sv
package dual_timer_pkg;

  // Mode select encodings
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_8BIT_AR = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // Prescale field encodings: divide-by counts
  localparam logic [1:0] SCALE_DIV12 = 2'h0;
  localparam logic [1:0] SCALE_DIV4  = 2'h1;
  localparam logic [1:0] SCALE_DIV48 = 2'h2;
  localparam logic [1:0] SCALE_EXT8  = 2'h3;

  localparam int unsigned DIV12_CYCLES = 12;
  localparam int unsigned DIV4_CYCLES  = 4;
  localparam int unsigned DIV48_CYCLES = 48;
  localparam int unsigned DIV8_CYCLES  = 8;

  // Count field positions and widths
  localparam int unsigned LOW5_MSB   = 4;
  localparam logic [4:0]  LOW5_ONES  = 5'h1f;
  localparam logic [7:0]  BYTE_ONES  = 8'hff;

  // Reset values
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [5:0]  DIV_RESET  = 6'h00;

endpackage : dual_timer_pkg

// file: logic/timer_channel.sv
`timescale 1ns/1ps
module timer_channel (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Configuration
  input  wire logic [1:0] mode_i,
  input  wire logic       count_select_i,
  input  wire logic       sysclk_select_i,
  input  wire logic       run_i,
  input  wire logic       gate_i,
  input  wire logic       gate_active_i,
  input  wire logic       presc_tick_i,
  input  wire logic       pin_fall_i,
  // Byte writes
  input  wire logic       wr_low_i,
  input  wire logic       wr_high_i,
  input  wire logic [7:0] wr_data_i,
  // Count and overflow
  output logic      [7:0] low_o,
  output logic      [7:0] high_o,
  output logic            ovf_o
);

  logic tick;
  logic enable;
  logic low_wrap;
  logic high_wrap;

  // Source select: pin edge, system clock or prescaled tick
  always_comb begin
    if (count_select_i) begin
      tick = pin_fall_i;
    end else if (sysclk_select_i) begin
      tick = 1'b1;
    end else begin
      tick = presc_tick_i;
    end
  end

  assign enable = run_i && (!gate_i || gate_active_i) && tick;

  always_comb begin
    case (mode_i)
      dual_timer_pkg::MODE_13BIT:
        low_wrap = (low_o[dual_timer_pkg::LOW5_MSB:0] ==
                    dual_timer_pkg::LOW5_ONES);
      default:
        low_wrap = (low_o == dual_timer_pkg::BYTE_ONES);
    endcase
  end

  assign high_wrap = low_wrap && (high_o == dual_timer_pkg::BYTE_ONES);

  // Low byte; write beats count, stop keeps value
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_o <= dual_timer_pkg::BYTE_RESET;
    end else if (wr_low_i) begin
      low_o <= wr_data_i;
    end else if (enable && mode_i != dual_timer_pkg::MODE_SPLIT) begin
      if (mode_i == dual_timer_pkg::MODE_8BIT_AR && low_wrap) begin
        low_o <= high_o;
      end else if (mode_i == dual_timer_pkg::MODE_13BIT && low_wrap) begin
        low_o <= {low_o[7:5], 5'h00};
      end else begin
        low_o <= low_o + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_o <= dual_timer_pkg::BYTE_RESET;
    end else if (wr_high_i) begin
      high_o <= wr_data_i;
    end else if (enable && low_wrap &&
                 (mode_i == dual_timer_pkg::MODE_13BIT ||
                  mode_i == dual_timer_pkg::MODE_16BIT)) begin
      high_o <= high_o + 8'h01;
    end
  end

  // One-cycle overflow event
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovf_o <= 1'b0;
    end else begin
      case (mode_i)
        dual_timer_pkg::MODE_13BIT,
        dual_timer_pkg::MODE_16BIT:
          ovf_o <= enable && high_wrap && !wr_low_i && !wr_high_i;
        dual_timer_pkg::MODE_8BIT_AR:
          ovf_o <= enable && low_wrap && !wr_low_i;
        default:
          ovf_o <= 1'b0;
      endcase
    end
  end

endmodule : timer_channel

// file: tb/dual_counter_timer_assertions.sv
`timescale 1ns/1ps
module dual_counter_timer_assertions (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic [1:0] first_mode_i,
  input wire logic       first_count_select_i,
  input wire logic       first_sysclk_select_i,
  input wire logic       first_run_bit_i,
  input wire logic       first_gate_bit_i,
  input wire logic       first_gate_polarity_i,
  input wire logic       first_gate_input_i,
  input wire logic       first_count_pin_i,
  input wire logic       first_low_wr_i,
  input wire logic       first_high_wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       first_flag_clear_i,
  input wire logic       first_irq_enable_i,
  input wire logic [7:0] first_timer_low_byte_o,
  input wire logic [7:0] first_timer_high_byte_o,
  input wire logic       first_overflow_flag_o,
  input wire logic       first_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic        no_wr = !first_low_wr_i && !first_high_wr_i;
  wire logic [15:0] cnt = {first_timer_high_byte_o, first_timer_low_byte_o};
  wire logic [12:0] c13 = {cnt[15:8], cnt[4:0]};
  wire logic        wrap = first_run_bit_i && !first_gate_bit_i && no_wr
    && first_mode_i == dual_timer_pkg::MODE_13BIT && !first_count_select_i
    && first_sysclk_select_i && c13 == 13'h1fff;
  low_write_a: assert property (
    first_low_wr_i |=> first_timer_low_byte_o == $past(wr_data_i))
    else $error("Low byte write lost");
  high_write_a: assert property (
    first_high_wr_i |=> first_timer_high_byte_o == $past(wr_data_i))
    else $error("High byte write lost");
  run_hold_a: assert property (
    !first_run_bit_i && no_wr |=> $stable(cnt))
    else $error("Count moved while stopped");
  gate_hold_a: assert property (
    (first_gate_input_i != first_gate_polarity_i)[*4] ##0
    (first_gate_bit_i && no_wr) |=> $stable(cnt))
    else $error("Count moved while gated off");
  wrap_flag_a: assert property (
    wrap |=> c13 == 13'h0000 ##1 first_overflow_flag_o)
    else $error("Wrap did not set flag");
  irq_enable_a: assert property (
    first_irq_o |-> $past(first_irq_enable_i))
    else $error("Interrupt while disabled");
  flag_clear_a: assert property (
    first_flag_clear_i && !first_run_bit_i && !$past(first_run_bit_i)
    |=> !first_overflow_flag_o)
    else $error("Flag not cleared");
  pin_quiet_a: assert property (
    $stable(first_count_pin_i)[*5] ##0 (first_count_select_i && no_wr)
    |=> $stable(cnt))
    else $error("Count moved without pin edge");
endmodule : dual_counter_timer_assertions

bind dual_counter_timer dual_counter_timer_assertions dca_i (.*);

// file: tb/dual_counter_timer_tb.sv
`timescale 1ns/1ps
module dual_counter_timer_tb;
  logic clk_i, rstn_i, ext_clk_tick_i;
  logic [1:0] first_mode_i, second_mode_i, prescale_field_i;
  logic first_count_select_i, second_count_select_i, first_sysclk_select_i;
  logic second_sysclk_select_i, first_run_bit_i, second_run_bit_i;
  logic first_gate_bit_i, second_gate_bit_i, first_gate_polarity_i;
  logic second_gate_polarity_i, first_irq_enable_i, second_irq_enable_i;
  logic first_flag_clear_i, second_flag_clear_i, first_vector_ack_i;
  logic second_vector_ack_i, first_count_pin_i, second_count_pin_i;
  logic first_gate_input_i, second_gate_input_i, first_low_wr_i;
  logic first_high_wr_i, second_low_wr_i, second_high_wr_i;
  logic [7:0] wr_data_i, first_timer_low_byte_o, first_timer_high_byte_o;
  logic [7:0] second_timer_low_byte_o, second_timer_high_byte_o;
  logic first_overflow_flag_o, second_overflow_flag_o;
  logic first_irq_o, second_irq_o;
  int bad_count, n_checks;
  int unsigned divs[4] = '{dual_timer_pkg::DIV12_CYCLES,
    dual_timer_pkg::DIV4_CYCLES, dual_timer_pkg::DIV48_CYCLES,
    dual_timer_pkg::DIV8_CYCLES};
  logic [15:0] ld[4] = '{16'h0000, 16'hfffe, 16'h80fe, 16'h1234};
  logic [15:0] ex[4] = '{16'h0003, 16'h0001, 16'h8081, 16'h1234};

  dual_counter_timer dual_counter_timer_i (.*);
  pin_source_model #(.GATE_IDLE(1'h1)) first_pins (.clk_i,
    .count_pin_o(first_count_pin_i), .gate_o(first_gate_input_i));
  pin_source_model #(.GATE_IDLE(1'h0)) second_pins (.clk_i,
    .count_pin_o(second_count_pin_i), .gate_o(second_gate_input_i));

  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic settle();
    tick(4);
    @(negedge clk_i);
  endtask : settle
  task automatic chk_cnt(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_cnt
  task automatic chk_bit(input string nm, input logic e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  // Raw bytes, and the 13-bit view with low bits 7:5 dropped
  function automatic logic [15:0] rd(input logic t);
    return t ? {second_timer_high_byte_o, second_timer_low_byte_o}
             : {first_timer_high_byte_o, first_timer_low_byte_o};
  endfunction : rd
  function automatic logic [15:0] n13(input logic [15:0] v);
    return {3'h0, v[15:8], v[4:0]};
  endfunction : n13
  task automatic load(input logic t, input logic [15:0] v);
    @(posedge clk_i);
    wr_data_i <= v[7:0];
    first_low_wr_i <= !t;
    second_low_wr_i <= t;
    @(posedge clk_i);
    wr_data_i <= v[15:8];
    {first_low_wr_i, second_low_wr_i} <= 2'h0;
    first_high_wr_i <= !t;
    second_high_wr_i <= t;
    @(posedge clk_i);
    {first_high_wr_i, second_high_wr_i} <= 2'h0;
  endtask : load
  task automatic run(input logic t, input int n);
    @(posedge clk_i);
    first_run_bit_i <= !t;
    second_run_bit_i <= t;
    tick(n);
    {first_run_bit_i, second_run_bit_i} <= 2'h0;
    settle();
  endtask : run
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {first_mode_i, second_mode_i, prescale_field_i, wr_data_i} = 14'h0;
    {first_count_select_i, second_count_select_i, first_sysclk_select_i,
     second_sysclk_select_i, first_run_bit_i, second_run_bit_i,
     first_gate_bit_i, second_gate_bit_i, first_gate_polarity_i,
     second_gate_polarity_i, first_irq_enable_i, second_irq_enable_i,
     first_flag_clear_i, second_flag_clear_i, first_vector_ack_i,
     second_vector_ack_i, first_low_wr_i, first_high_wr_i,
     second_low_wr_i, second_high_wr_i} = 20'h0;
    ext_clk_tick_i = 1'h1;
    rstn_i = 1'h0;
    tick(20);
    rstn_i <= 1'h1;
    settle();
    chk_cnt("first reset", 16'h0000, rd(1'h0));
    chk_cnt("second reset", 16'h0000, rd(1'h1));
    chk_bit("reset flag", 1'h0, first_overflow_flag_o);
    @(posedge clk_i);
    first_sysclk_select_i <= 1'h1;
    first_irq_enable_i <= 1'h1;
    load(1'h0, 16'hfffd);
    run(1'h0, 3);
    chk_cnt("wrap count", 16'h0000, n13(rd(1'h0)));
    chk_bit("wrap flag", 1'h1, first_overflow_flag_o);
    chk_bit("wrap irq", 1'h1, first_irq_o);
    @(posedge clk_i);
    first_flag_clear_i <= 1'h1;
    @(posedge clk_i);
    first_flag_clear_i <= 1'h0;
    settle();
    chk_bit("cleared flag", 1'h0, first_overflow_flag_o);
    run(1'h0, 5);
    run(1'h0, 2);
    chk_cnt("resumed count", 16'h0007, n13(rd(1'h0)));
    @(posedge clk_i);
    first_sysclk_select_i <= 1'h0;
    foreach (divs[i]) begin
      @(posedge clk_i);
      prescale_field_i <= 2'(i);
      tick(48);
      load(1'h0, 16'h0000);
      run(1'h0, 96);
      chk_cnt("prescaled", 16'(96 / divs[i]), n13(rd(1'h0)));
    end
    @(posedge clk_i);
    second_sysclk_select_i <= 1'h1;
    second_irq_enable_i <= 1'h1;
    foreach (ld[i]) begin
      @(posedge clk_i);
      second_mode_i <= 2'(i);
      load(1'h1, ld[i]);
      run(1'h1, 3);
      chk_cnt("second mode", ex[i], rd(1'h1));
    end
    chk_bit("second flag", 1'h1, second_overflow_flag_o);
    chk_bit("second irq", 1'h1, second_irq_o);
    @(posedge clk_i);
    second_vector_ack_i <= 1'h1;
    @(posedge clk_i);
    second_vector_ack_i <= 1'h0;
    settle();
    chk_bit("second acked", 1'h0, second_overflow_flag_o);
    chk_bit("second irq off", 1'h0, second_irq_o);
    @(posedge clk_i);
    first_count_select_i <= 1'h1;
    load(1'h0, 16'h0000);
    first_run_bit_i <= 1'h1;
    first_pins.falls(4);
    tick(6);
    first_run_bit_i <= 1'h0;
    settle();
    chk_cnt("pin count", 16'h0004, n13(rd(1'h0)));
    @(posedge clk_i);
    second_mode_i <= dual_timer_pkg::MODE_16BIT;
    second_count_select_i <= 1'h1;
    second_gate_bit_i <= 1'h1;
    second_gate_polarity_i <= 1'h1;
    load(1'h1, 16'h0000);
    second_run_bit_i <= 1'h1;
    second_pins.falls(3);
    second_pins.gate_level(1'h1);
    tick(4);
    second_pins.falls(2);
    tick(6);
    second_run_bit_i <= 1'h0;
    settle();
    chk_cnt("gated pin count", 16'h0002, rd(1'h1));
    @(posedge clk_i);
    first_count_select_i <= 1'h0;
    first_sysclk_select_i <= 1'h1;
    first_gate_bit_i <= 1'h1;
    first_gate_polarity_i <= 1'h0;
    load(1'h0, 16'h0000);
    first_run_bit_i <= 1'h1;
    tick(8);
    first_pins.gate_level(1'h0);
    tick(19);
    first_pins.gate_level(1'h1);
    tick(8);
    first_run_bit_i <= 1'h0;
    settle();
    chk_cnt("pulse width", 16'h0014, n13(rd(1'h0)));
    @(posedge clk_i);
    first_gate_bit_i <= 1'h0;
    first_irq_enable_i <= 1'h0;
    first_mode_i <= dual_timer_pkg::MODE_16BIT;
    load(1'h0, 16'hffff);
    run(1'h0, 1);
    chk_cnt("long wrap", 16'h0000, rd(1'h0));
    chk_bit("masked flag", 1'h1, first_overflow_flag_o);
    chk_bit("masked irq", 1'h0, first_irq_o);
    @(posedge clk_i);
    first_vector_ack_i <= 1'h1;
    @(posedge clk_i);
    first_vector_ack_i <= 1'h0;
    settle();
    chk_bit("acked flag", 1'h0, first_overflow_flag_o);
    give_verdict();
  end
endmodule : dual_counter_timer_tb

// file: tb/pin_source_model.sv
`timescale 1ns/1ps
module pin_source_model #(
  parameter logic GATE_IDLE = 1'h1
) (
  input  wire logic clk_i,
  output logic      count_pin_o,
  output logic      gate_o
);
  initial begin
    count_pin_o = 1'h1;
    gate_o      = GATE_IDLE;
  end
  // Two clocks per level, so a quarter of the clock rate
  task automatic falls(input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_pin_o <= 1'h0;
      repeat (2) @(posedge clk_i);
      count_pin_o <= 1'h1;
      @(posedge clk_i);
    end
  endtask : falls
  task automatic gate_level(input logic l);
    @(posedge clk_i);
    gate_o <= l;
  endtask : gate_level
endmodule : pin_source_model
